// *** common/pulse_counter_pkg.sv ***
// constants for the eight-input pulse counter pair
package pulse_counter_pkg;
  localparam int NUM_INPUTS = 8;
  localparam int OBJ_BASE   = 10;
  localparam int OBJ_STRIDE = 10;
  localparam logic [7:0] OBJ_BLOCK   = 8'h00;
  localparam logic [7:0] OBJ_MAIN    = 8'h01;
  localparam logic [7:0] OBJ_DIFF    = 8'h02;
  localparam logic [7:0] OBJ_DLIMIT  = 8'h05;
  localparam logic [2:0] FMT_U8  = 3'h0;
  localparam logic [2:0] FMT_S8  = 3'h1;
  localparam logic [2:0] FMT_U16 = 3'h2;
  localparam logic [2:0] FMT_S16 = 3'h3;
  localparam logic [2:0] FMT_S32 = 3'h4;
  localparam logic [31:0] MAX_U8  = 32'h0000_00FF;
  localparam logic [31:0] MAX_S8  = 32'h0000_007F;
  localparam logic [31:0] MAX_U16 = 32'h0000_FFFF;
  localparam logic [31:0] MAX_S16 = 32'h0000_7FFF;
  localparam logic [31:0] MAX_S32 = 32'h7FFF_FFFF;
  localparam logic [31:0] LIMIT1_RESET = 32'h0000_0000;
  localparam logic [13:0] PULSES_MAX   = 14'h2710;
  localparam logic [13:0] PULSES_RESET = 14'h0001;
  localparam logic [15:0] SEND_DELAY_RESET = 16'h0010;
  localparam logic [15:0] CYCLE_RESET      = 16'h0100;
endpackage : pulse_counter_pkg

// *** logic/input_pulse_counter_pair.sv ***
// eight-input pulse counter with main and differential tallies
`timescale 1ns/10ps

// Notes on behaviour
// - after restart, wait the send delay then send the main tally
// - send a tally on every change only when that option is set
// - send tallies periodically when the cyclic option is set
// - difference tally formats: u8, s8, u16, s16, s32
// - a step past a limit loads the opposite limit; next step counts on
// - larger limit is the upper bound whatever order they are given
// - limit one resets to zero, limit two to the format maximum
// - circular: below lower loads upper, above upper loads lower
// - stop mode halts on crossing until configuration reset
// - difference tally follows main direction unless reversed
// - input n owns object numbers 10n+10 to 10n+19
// - disable object: 0 enables the input, 1 disables it
// - while disabled ignore the signal but keep updating and sending
// - on re-enable a changed signal is processed at once
// - disable does not touch manual operation or its status sends
// - disabling ends a running scene operation and saves it
// - main tally object is send-only, encoded per format
// - difference tally object exists only when enabled
// - disabled inputs do not count
// - send 1 on the limit object when a difference limit is crossed
// - reverse object 1 reverses, 0 restores the configured direction
// - one counter step per 1 to 10000 input pulses
module input_pulse_counter_pair (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [7:0]  pulseIn,
  input  wire logic [7:0]  manualIn,
  input  wire logic        cfgReset,
  input  wire logic        busRecover,
  input  wire logic [7:0]  blockWrite,
  input  wire logic [7:0]  blockValue,
  input  wire logic [7:0]  reverseWrite,
  input  wire logic [7:0]  reverseValue,
  input  wire logic [7:0]  diffEnable,
  input  wire logic [7:0]  sendOnRestart,
  input  wire logic [7:0]  sendOnChange,
  input  wire logic [7:0]  sendCyclic,
  input  wire logic [7:0]  stopMode,
  input  wire logic [7:0]  cfgReverse,
  input  wire logic [2:0]  mainFormat,
  input  wire logic [2:0]  diffFormat,
  input  wire logic        countDown,
  input  wire logic [13:0] pulsesPerStep,
  input  wire logic        limitWrite,
  input  wire logic [31:0] limit1Value,
  input  wire logic [31:0] limit2Value,
  input  wire logic [15:0] sendDelay,
  input  wire logic [15:0] cyclePeriod,
  input  wire logic        sendReady,
  output logic             sendValid,
  output logic [7:0]       sendObject,
  output logic [31:0]      sendData,
  output logic [7:0]       manualStatus,
  output logic [7:0]       inputDisabled,
  output logic [7:0]       sceneSave
);
  localparam int N = pulse_counter_pkg::NUM_INPUTS;

  // ============================================================
  // input synchronisers
  logic [7:0] pulseMeta, pulseSync, pulseLast, manualMeta;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pulseMeta    <= 8'h00;
      pulseSync    <= 8'h00;
      manualMeta   <= 8'h00;
      manualStatus <= 8'h00;
    end else begin
      pulseMeta    <= pulseIn;
      pulseSync    <= pulseMeta;
      manualMeta   <= manualIn;
      manualStatus <= manualMeta;
    end
  end

  // ============================================================
  // format helpers
  function automatic logic [31:0] fmtMax(input logic [2:0] f);
    case (f)
      pulse_counter_pkg::FMT_U8:  fmtMax = pulse_counter_pkg::MAX_U8;
      pulse_counter_pkg::FMT_S8:  fmtMax = pulse_counter_pkg::MAX_S8;
      pulse_counter_pkg::FMT_U16: fmtMax = pulse_counter_pkg::MAX_U16;
      pulse_counter_pkg::FMT_S16: fmtMax = pulse_counter_pkg::MAX_S16;
      default:                    fmtMax = pulse_counter_pkg::MAX_S32;
    endcase
  endfunction : fmtMax

  // encode a tally in the low bytes of the object value
  function automatic logic [31:0] fmtEncode(input logic [2:0] f, input logic [31:0] v);
    case (f)
      pulse_counter_pkg::FMT_U8, pulse_counter_pkg::FMT_S8:   fmtEncode = {24'h00_0000, v[7:0]};
      pulse_counter_pkg::FMT_U16, pulse_counter_pkg::FMT_S16: fmtEncode = {16'h0000, v[15:0]};
      default:                                                fmtEncode = v;
    endcase
  endfunction : fmtEncode

  // ============================================================
  // disable object and re-enable handling
  logic [7:0] signalAtBlock, pendingEdge;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      inputDisabled <= 8'h00;
      signalAtBlock <= 8'h00;
      pendingEdge   <= 8'h00;
      sceneSave     <= 8'h00;
    end else begin
      sceneSave   <= 8'h00;
      pendingEdge <= 8'h00;
      for (int i = 0; i < N; i++) begin
        if (blockWrite[i]) begin
          if (blockValue[i] && !inputDisabled[i]) begin
            inputDisabled[i] <= 1'b1;
            signalAtBlock[i] <= pulseSync[i];
            sceneSave[i]     <= 1'b1;
          end else if (!blockValue[i] && inputDisabled[i]) begin
            inputDisabled[i] <= 1'b0;
            pendingEdge[i]   <= pulseSync[i] & ~signalAtBlock[i];
          end
        end
      end
    end
  end

  // ============================================================
  // limits, shared by all inputs
  logic [31:0] limit1, limit2;
  logic        limitsCustom;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      limit1       <= pulse_counter_pkg::LIMIT1_RESET;
      limit2       <= pulse_counter_pkg::MAX_S32;
      limitsCustom <= 1'b0;
    end else if (limitWrite) begin
      limit1       <= limit1Value;
      limit2       <= limit2Value;
      limitsCustom <= 1'b1;
    end
  end
  logic [31:0] lim2Eff, upper, lower;
  logic        fmtSigned;
  always_comb begin
    lim2Eff   = limitsCustom ? limit2 : fmtMax(diffFormat);
    fmtSigned = (diffFormat == pulse_counter_pkg::FMT_S8) ||
                (diffFormat == pulse_counter_pkg::FMT_S16) ||
                (diffFormat == pulse_counter_pkg::FMT_S32);
    if (fmtSigned ? ($signed(limit1) > $signed(lim2Eff)) : (limit1 > lim2Eff)) begin
      upper = limit1;
      lower = lim2Eff;
    end else begin
      upper = lim2Eff;
      lower = limit1;
    end
  end

  // ============================================================
  // per-input tallies
  logic [31:0] mainTally [N];
  logic [31:0] diffTally [N];
  logic [13:0] prescale  [N];
  logic [7:0]  diffStopped, reverseObj, mainChanged, diffChanged, limitHit;
  logic [7:0]  rise;
  assign rise = (pulseSync & ~pulseLast) | pendingEdge;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pulseLast   <= 8'h00;
      diffStopped <= 8'h00;
      reverseObj  <= 8'h00;
      mainChanged <= 8'h00;
      diffChanged <= 8'h00;
      limitHit    <= 8'h00;
      for (int i = 0; i < N; i++) begin
        mainTally[i] <= 32'h0000_0000;
        diffTally[i] <= 32'h0000_0000;
        prescale[i]  <= 14'h0000;
      end
    end else begin
      pulseLast   <= pulseSync;
      mainChanged <= 8'h00;
      diffChanged <= 8'h00;
      limitHit    <= 8'h00;
      for (int i = 0; i < N; i++) begin
        if (reverseWrite[i])
          reverseObj[i] <= reverseValue[i];
        if (cfgReset) begin
          diffStopped[i] <= 1'b0;
          prescale[i]    <= 14'h0000;
          diffTally[i]   <= lower;
        end else if (rise[i] && !inputDisabled[i]) begin
          if (prescale[i] + 14'h0001 >= pulsesPerStep) begin
            prescale[i]    <= 14'h0000;
            mainTally[i]   <= countDown ? mainTally[i] - 32'h0000_0001
                                        : mainTally[i] + 32'h0000_0001;
            mainChanged[i] <= 1'b1;
            if (diffEnable[i] && !diffStopped[i]) begin
              diffChanged[i] <= 1'b1;
              if (countDown ^ cfgReverse[i] ^ reverseObj[i]) begin
                if (diffTally[i] == lower) begin
                  limitHit[i] <= 1'b1;
                  if (stopMode[i]) {diffStopped[i], diffChanged[i]} <= 2'b10;
                  else diffTally[i] <= upper;
                end else
                  diffTally[i] <= diffTally[i] - 32'h0000_0001;
              end else begin
                if (diffTally[i] == upper) begin
                  limitHit[i] <= 1'b1;
                  if (stopMode[i]) {diffStopped[i], diffChanged[i]} <= 2'b10;
                  else diffTally[i] <= lower;
                end else
                  diffTally[i] <= diffTally[i] + 32'h0000_0001;
              end
            end
          end else
            prescale[i] <= prescale[i] + 14'h0001;
        end
      end
    end
  end

  // ============================================================
  // send scheduling: pending flags, set wins over clear
  logic [15:0] delayCount, cycleCount;
  logic        delayRunning;
  logic [7:0]  pendMain, pendDiff, pendLimit;
  logic        cycleTick, restartTick;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      delayCount   <= 16'h0000;
      delayRunning <= 1'b0;
      cycleCount   <= 16'h0000;
    end else begin
      if (cfgReset || busRecover) begin
        delayRunning <= 1'b1;
        delayCount   <= sendDelay;
      end else if (delayRunning) begin
        if (delayCount == 16'h0000) delayRunning <= 1'b0;
        else delayCount <= delayCount - 16'h0001;
      end
      cycleCount <= cycleTick ? 16'h0000 : cycleCount + 16'h0001;
    end
  end
  assign restartTick = delayRunning && (delayCount == 16'h0000);
  assign cycleTick   = (cycleCount >= cyclePeriod);

  // ============================================================
  // object sender, one object at a time
  logic [3:0] pick;
  logic [1:0] pickKind;
  always_comb begin
    pick     = 4'h8;
    pickKind = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pendLimit[i]) begin pick = 4'(i); pickKind = 2'h2; end
      else if (pendDiff[i]) begin pick = 4'(i); pickKind = 2'h1; end
      else if (pendMain[i]) begin pick = 4'(i); pickKind = 2'h0; end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pendMain   <= 8'h00;
      pendDiff   <= 8'h00;
      pendLimit  <= 8'h00;
      sendValid  <= 1'b0;
      sendObject <= 8'h00;
      sendData   <= 32'h0000_0000;
    end else begin
      logic [7:0] clrM, clrD, clrL;
      clrM = 8'h00;
      clrD = 8'h00;
      clrL = 8'h00;
      if (sendValid && sendReady)
        sendValid <= 1'b0;
      else if (!sendValid && !pick[3]) begin
        sendValid <= 1'b1;
        sendObject <= 8'(pulse_counter_pkg::OBJ_BASE + pulse_counter_pkg::OBJ_STRIDE * pick[2:0]);
        case (pickKind)
          2'h2: begin
            sendObject <= 8'(pulse_counter_pkg::OBJ_BASE + pulse_counter_pkg::OBJ_STRIDE * pick[2:0])
                          + pulse_counter_pkg::OBJ_DLIMIT;
            sendData   <= 32'h0000_0001;
            clrL[pick[2:0]] = 1'b1;
          end
          2'h1: begin
            sendObject <= 8'(pulse_counter_pkg::OBJ_BASE + pulse_counter_pkg::OBJ_STRIDE * pick[2:0])
                          + pulse_counter_pkg::OBJ_DIFF;
            sendData   <= fmtEncode(diffFormat, diffTally[pick[2:0]]);
            clrD[pick[2:0]] = 1'b1;
          end
          default: begin
            sendObject <= 8'(pulse_counter_pkg::OBJ_BASE + pulse_counter_pkg::OBJ_STRIDE * pick[2:0])
                          + pulse_counter_pkg::OBJ_MAIN;
            sendData   <= fmtEncode(mainFormat, mainTally[pick[2:0]]);
            clrM[pick[2:0]] = 1'b1;
          end
        endcase
      end
      // set wins over clear
      pendMain  <= (pendMain & ~clrM) | (mainChanged & sendOnChange)
                 | ({8{cycleTick}} & sendCyclic)
                 | ({8{restartTick}} & sendOnRestart);
      pendDiff  <= (pendDiff & ~clrD) | ((diffChanged & sendOnChange)
                 | ({8{cycleTick}} & sendCyclic)
                 | ({8{restartTick}} & sendOnRestart)) & diffEnable;
      pendLimit <= (pendLimit & ~clrL) | limitHit;
    end
  end

  // ============================================================
  // checks
  stop_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (diffStopped[1] && !cfgReset) |=> $stable(diffTally[1]))
    else $error("stopped difference tally moved");
  disabled_nocount_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (inputDisabled[0] && !pendingEdge[0]) |=> !mainChanged[0])
    else $error("disabled input counted");
  limit_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (limitHit != 8'h00) |=> ((pendLimit & $past(limitHit)) == $past(limitHit)))
    else $error("limit crossing not queued");
  object_range_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    sendValid |-> (sendObject >= 8'h0A && sendObject <= 8'h59))
    else $error("object number out of range");
  scene_save_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (blockWrite[0] && blockValue[0] && !inputDisabled[0]) |=> (sceneSave[0] && inputDisabled[0]))
    else $error("disable did not save the scene");
  restart_send_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    restartTick |=> ((pendMain & $past(sendOnRestart)) == $past(sendOnRestart)))
    else $error("restart send not queued");
endmodule : input_pulse_counter_pair

// *** tb/bus_sink_model.sv ***
// bus side model that accepts telegrams and records them in order
`timescale 1ns/10ps
module bus_sink_model (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        slow,
  input  wire logic        sendValid,
  input  wire logic [7:0]  sendObject,
  input  wire logic [31:0] sendData,
  output logic             sendReady
);
  logic [39:0] seen[$];
  int          holdOff;
  // ============================================================
  // handshake: prompt, or three cycles late when slow
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sendReady <= 1'b0;
      holdOff   <= 0;
    end else if (sendValid && sendReady) begin
      seen.push_back({sendObject, sendData});
      sendReady <= 1'b0;
      holdOff   <= 0;
    end else if (sendValid) begin
      holdOff   <= holdOff + 1;
      sendReady <= !slow || holdOff >= 3;
    end
  end
endmodule : bus_sink_model

// *** tb/test_input_pulse_counter_pair.sv ***
// self-checking bench for the eight-input pulse counter
`timescale 1ns/10ps
module test_input_pulse_counter_pair;
  logic        clk_sys, resetn, cfgReset, busRecover, countDown, limitWrite, slow;
  logic        sendReady, sendValid, sceneSeen;
  logic [7:0]  pulseIn, manualIn, blockWrite, blockValue, reverseWrite, reverseValue;
  logic [7:0]  diffEnable, sendOnRestart, sendOnChange, sendCyclic, stopMode, cfgReverse;
  logic [7:0]  sendObject, manualStatus, inputDisabled, sceneSave;
  logic [31:0] limit1Value, limit2Value, sendData;
  logic [2:0]  mainFormat, diffFormat;
  logic [13:0] pulsesPerStep;
  logic [15:0] cyclePeriod;
  int          bad_count, checked;
  input_pulse_counter_pair dut (.clk_sys(clk_sys), .resetn(resetn), .pulseIn(pulseIn),
    .manualIn(manualIn), .cfgReset(cfgReset), .busRecover(busRecover),
    .blockWrite(blockWrite), .blockValue(blockValue), .reverseWrite(reverseWrite),
    .reverseValue(reverseValue), .diffEnable(diffEnable), .sendOnRestart(sendOnRestart),
    .sendOnChange(sendOnChange), .sendCyclic(sendCyclic), .stopMode(stopMode),
    .cfgReverse(cfgReverse), .mainFormat(mainFormat),
    .diffFormat(diffFormat), .countDown(countDown),
    .pulsesPerStep(pulsesPerStep), .limitWrite(limitWrite),
    .limit1Value(limit1Value), .limit2Value(limit2Value),
    .sendDelay(pulse_counter_pkg::SEND_DELAY_RESET),
    .cyclePeriod(cyclePeriod), .sendReady(sendReady), .sendValid(sendValid),
    .sendObject(sendObject), .sendData(sendData), .manualStatus(manualStatus),
    .inputDisabled(inputDisabled), .sceneSave(sceneSave));
  bus_sink_model bus (.clk_sys(clk_sys), .resetn(resetn), .slow(slow),
    .sendValid(sendValid), .sendObject(sendObject), .sendData(sendData),
    .sendReady(sendReady));
  // ============================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : step
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [7:0] objnum(input int i, input logic [7:0] off);
    return 8'(pulse_counter_pkg::OBJ_BASE + pulse_counter_pkg::OBJ_STRIDE * i) + off;
  endfunction : objnum
  task automatic pulse(input int i);
    pulseIn[i] = 1'b1;
    step(2);
    pulseIn[i] = 1'b0;
    step(2);
  endtask : pulse
  // skips telegrams of other objects until the wanted one arrives
  task automatic expect_tel(input logic [7:0] obj, input logic [31:0] data);
    logic [39:0] t;
    int          n;
    t = '0;
    n = 0;
    while (t[39:32] !== obj && n < 80) begin
      if (bus.seen.size() > 0) t = bus.seen.pop_front();
      else step(1);
      n++;
    end
    cmp(t, {obj, data});
  endtask : expect_tel
  task automatic no_tel(input logic [7:0] obj);
    int hits;
    hits = 0;
    step(40);
    foreach (bus.seen[k]) if (bus.seen[k][39:32] === obj) hits++;
    cmp(hits, 0);
  endtask : no_tel
  task automatic block(input int i, input logic v);
    blockWrite[i] = 1'b1;
    blockValue[i] = v;
    step(1);
    blockWrite[i] = 1'b0;
  endtask : block
  task automatic reverse(input int i, input logic v);
    reverseWrite[i] = 1'b1;
    reverseValue[i] = v;
    step(1);
    reverseWrite[i] = 1'b0;
  endtask : reverse
  task automatic cfg_reset;
    cfgReset = 1'b1;
    step(1);
    cfgReset = 1'b0;
    step(2);
  endtask : cfg_reset
  // ============================================================
  // scenarios
  task automatic test_change;
    sendOnChange = 8'h85;
    pulse(0);
    expect_tel(objnum(0, pulse_counter_pkg::OBJ_MAIN), 32'h0000_0001);
    pulse(2);
    expect_tel(objnum(2, pulse_counter_pkg::OBJ_MAIN), 32'h0000_0001);
    pulse(7);
    expect_tel(objnum(7, pulse_counter_pkg::OBJ_MAIN), 32'h0000_0001);
  endtask : test_change
  task automatic test_block;
    block(0, 1'b1);
    step(1);
    cmp(inputDisabled[0], 1'b1);
    cmp(sceneSeen, 1'b1);
    manualIn[0] = 1'b1;
    step(4);
    cmp(manualStatus[0], 1'b1);
    bus.seen.delete();
    pulse(0);
    no_tel(objnum(0, pulse_counter_pkg::OBJ_MAIN));
    pulseIn[0] = 1'b1;
    step(4);
    block(0, 1'b0);
    expect_tel(objnum(0, pulse_counter_pkg::OBJ_MAIN), 32'h0000_0002);
    cmp(inputDisabled[0], 1'b0);
    pulseIn[0] = 1'b0;
  endtask : test_block
  task automatic test_diff;
    logic [31:0] up[5];
    up = '{32'h0000_0003, 32'h0000_0004, 32'h0000_0005, 32'h0000_0002, 32'h0000_0003};
    diffEnable[1] = 1'b1;
    sendOnChange[1] = 1'b1;
    // limits given high first and always unequal
    limit1Value = 32'h0000_0005;
    limit2Value = 32'h0000_0002;
    limitWrite = 1'b1;
    step(1);
    limitWrite = 1'b0;
    cfg_reset();
    bus.seen.delete();
    for (int k = 0; k < 5; k++) begin
      pulse(1);
      if (k == 3) expect_tel(objnum(1, pulse_counter_pkg::OBJ_DLIMIT), 32'h0000_0001);
      expect_tel(objnum(1, pulse_counter_pkg::OBJ_DIFF), up[k]);
    end
    reverse(1, 1'b1);
    pulse(1);
    expect_tel(objnum(1, pulse_counter_pkg::OBJ_DIFF), 32'h0000_0002);
    pulse(1);
    expect_tel(objnum(1, pulse_counter_pkg::OBJ_DIFF), 32'h0000_0005);
    reverse(1, 1'b0);
    stopMode[1] = 1'b1;
    step(20);
    bus.seen.delete();
    pulse(1);
    no_tel(objnum(1, pulse_counter_pkg::OBJ_DIFF));
    cfg_reset();
    pulse(1);
    expect_tel(objnum(1, pulse_counter_pkg::OBJ_DIFF), 32'h0000_0003);
  endtask : test_diff
  task automatic test_restart;
    int n;
    n = 0;
    slow = 1'b1;
    sendOnRestart = 8'h08;
    step(20);
    bus.seen.delete();
    busRecover = 1'b1;
    step(1);
    busRecover = 1'b0;
    while (bus.seen.size() == 0 && n < 200) begin
      step(1);
      n++;
    end
    cmp(n >= 16 && n <= 26, 1'b1);
    expect_tel(objnum(3, pulse_counter_pkg::OBJ_MAIN), 32'h0000_0000);
  endtask : test_restart
  task automatic test_format;
    mainFormat      = pulse_counter_pkg::FMT_U16;
    diffFormat      = pulse_counter_pkg::FMT_S8;
    pulsesPerStep   = 14'h0003;
    countDown       = 1'b1;
    diffEnable[4]   = 1'b1;
    sendOnChange[4] = 1'b1;
    // a reset in mid-run drops the written limits back to the format defaults
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    step(2);
    bus.seen.delete();
    pulse(4);
    pulse(4);
    no_tel(objnum(4, pulse_counter_pkg::OBJ_MAIN));
    pulse(4);
    expect_tel(objnum(4, pulse_counter_pkg::OBJ_DLIMIT), 32'h0000_0001);
    expect_tel(objnum(4, pulse_counter_pkg::OBJ_DIFF), 32'h0000_007F);
    expect_tel(objnum(4, pulse_counter_pkg::OBJ_MAIN), 32'h0000_FFFF);
    cyclePeriod = 16'h0010;
    sendCyclic  = 8'h11;
    bus.seen.delete();
    no_tel(objnum(0, pulse_counter_pkg::OBJ_DIFF));
    expect_tel(objnum(0, pulse_counter_pkg::OBJ_MAIN), 32'h0000_0000);
    expect_tel(objnum(4, pulse_counter_pkg::OBJ_MAIN), 32'h0000_FFFF);
  endtask : test_format
  // ============================================================
  // run control
  task automatic end_of_test;
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (sceneSave[0] === 1'b1) sceneSeen = 1'b1;
  initial begin
    #(25 * 20000);
    bad_count++;
    end_of_test();
  end
  initial begin
    {resetn, cfgReset, busRecover, countDown, limitWrite, slow, sceneSeen} = '0;
    {pulseIn, manualIn, blockWrite, blockValue, reverseWrite, reverseValue} = '0;
    {diffEnable, sendOnRestart, sendOnChange, sendCyclic, stopMode, cfgReverse} = '0;
    limit1Value = pulse_counter_pkg::LIMIT1_RESET;
    limit2Value = pulse_counter_pkg::MAX_U8;
    mainFormat = pulse_counter_pkg::FMT_U8;
    diffFormat = pulse_counter_pkg::FMT_U8;
    pulsesPerStep = pulse_counter_pkg::PULSES_RESET;
    cyclePeriod = pulse_counter_pkg::CYCLE_RESET;
    bad_count = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys);
    #2 resetn = 1'b1;
    step(2);
    test_change();
    test_block();
    test_diff();
    test_restart();
    test_format();
    end_of_test();
  end
endmodule : test_input_pulse_counter_pair
